/* pkg/panel_map.svh */
`ifndef PANEL_MAP_SVH
`define PANEL_MAP_SVH

// key codes
`define KEY_DIGIT_MAX      5'h09
`define KEY_ENTER          5'h0a
`define KEY_RESET          5'h0b
`define KEY_SET_FIRST      5'h0c
`define KEY_FILT_FIRST     5'h11
`define KEY_FILT_LAST      5'h13
`define KEY_SET_LAST       5'h15
`define KEY_STORE_SEL      5'h01
`define KEY_ADDR_SEL       5'h03
`define KEY_RECALL_SEL     5'h06

// settings and setup slots
`define NUM_SETTINGS       10
`define NUM_SLOTS          10
`define SET_WARN_IDX       8
`define SET_ALERT_IDX      9
`define SETTING_RESET      16'h0000
`define ALARM_LEVEL_RESET  16'h03ff

// serial address
`define ADDR_RESET         5'h00
`define ADDR_MAX           5'h10

// timing
`define CLK_FREQ_KHZ       100000
`define SHOW_TIMEOUT_MS    20000
`define BANNER_TIMEOUT_MS  3000

`endif

/* pkg/panel_pkg.sv */
`default_nettype none

package panel_pkg;

  typedef enum logic [2:0]
  {
    ST_NORMAL,
    ST_SHOW,
    ST_PREFIX,
    ST_STORE,
    ST_RECALL,
    ST_ADDR,
    ST_BANNER
  } state_type;

  typedef enum logic [2:0]
  {
    DISP_READOUT,
    DISP_SETTING,
    DISP_OVERLOAD,
    DISP_STORE,
    DISP_RECALL,
    DISP_ADDR,
    DISP_LOCKED,
    DISP_UNLOCKED
  } disp_kind_type;

endpackage

`default_nettype wire

/* hw/key_event.sv */
`default_nettype none

module key_event
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // debounced key level
  input  wire logic       key_valid,
  input  wire logic [4:0] key_code,
  // one pulse per press
  output logic            press,
  output logic [4:0]      press_code
);

  logic held_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
      held_reg <= 1'b1;
    else
      held_reg <= key_valid;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      press      <= 1'b0;
      press_code <= 5'h00;
    end
    else
    begin
      press      <= key_valid && !held_reg;
      press_code <= key_code;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  press_once_a: assert property (press |=> !press)
    else $error("key press pulse longer than one cycle");

  press_edge_a: assert property (key_valid && $past(key_valid) |=> !press)
    else $error("held key produced a second press");

endmodule

`default_nettype wire

/* hw/panel_keypad_command_fsm.sv */
// Functional notes
// - after reset the unit is in panel mode, keys only from keypad
// - remote command enters serial mode only with option fitted and strap
// - panel mode readout (normal state only) shows flashing overload while AC or DC output overloads
// - warning and alert LEDs light when DC value exceeds their levels
// - setting key shows setting; ENTER accepts and returns to readout
// - shown setting returns to readout by itself after about 20 s
// - filter keys need filter option; address sequence needs serial option
// - reset key clears warning and alert alarm states together
// - ENTER then 1 enters store mode with flashing prompt; ten slots
// - slot digit then ENTER in store mode saves setup, back to normal
// - store or recall mode with no key leaves by itself to normal
// - ENTER then 6 enters recall mode with flashing recall prompt
// - slot digit then ENTER in recall mode loads setup, back to normal
// - ENTER then reset toggles the keyboard lock
// - locked keyboard ignores all but ENTER and reset; locked banner
// - unlocking shows the unlocked banner for a few seconds
// - serial mode continuously shows the serial address readout
// - serial mode lets the host program every keypad setting
// - ENTER then 3 shows address; value 0 to 16 then ENTER installs
// - address zero disables serial mode and is the reset address
// - up to 16 units share a host; one addressed talker at a time
`include "panel_map.svh"
`default_nettype none

module panel_keypad_command_fsm
#(
  parameter int              SET_W         = 10,
  parameter int              NUM_SLOT      = `NUM_SLOTS,
  parameter longint unsigned SHOW_CYCLES   =
    longint'(`SHOW_TIMEOUT_MS) * longint'(`CLK_FREQ_KHZ),
  parameter longint unsigned BANNER_CYCLES =
    longint'(`BANNER_TIMEOUT_MS) * longint'(`CLK_FREQ_KHZ)
)
(
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RST,
  // keypad
  input  wire logic             KEY_VALID,
  input  wire logic [4:0]       KEY_CODE,
  // option straps
  input  wire logic             FILTER_FITTED,
  input  wire logic             SERIAL_FITTED,
  input  wire logic             MODE_STRAP,
  // serial host
  input  wire logic             REMOTE_CMD,
  input  wire logic             LOCAL_CMD,
  input  wire logic             HOST_SET_VALID,
  input  wire logic [3:0]       HOST_SET_SEL,
  input  wire logic [SET_W-1:0] HOST_SET_DATA,
  // measurement status
  input  wire logic             AC_OVERLOAD,
  input  wire logic             DC_OVERLOAD,
  input  wire logic [SET_W-1:0] DC_VALUE,
  // display and indicators
  output var panel_pkg::disp_kind_type DISP_KIND,
  output logic [SET_W-1:0]      DISP_VALUE,
  output logic                  DISP_FLASH,
  output logic                  WARN_LED,
  output logic                  ALERT_LED,
  output logic                  REMOTE_MODE,
  output logic                  KBD_LOCKED,
  output logic [4:0]            SERIAL_ADDR
);

  localparam int NUM_SET = `NUM_SETTINGS;
  localparam logic [31:0] SHOW_LAST   = 32'(SHOW_CYCLES - 1);
  localparam logic [31:0] BANNER_LAST = 32'(BANNER_CYCLES - 1);

  if (SET_W < 5 || SET_W > 16 || NUM_SLOT < 1 || NUM_SLOT > 10 ||
      SHOW_CYCLES < 1 || SHOW_CYCLES > 64'h0000_0000_ffff_ffff ||
      BANNER_CYCLES < 1 || BANNER_CYCLES > 64'h0000_0000_ffff_ffff)
  begin : bad_params
    $error("unsupported parameter values");
  end

  function automatic logic is_digit(input logic [4:0] c);
    return c <= `KEY_DIGIT_MAX;
  endfunction

  function automatic logic setting_key(input logic [4:0] c,
                                       input logic       filt);
    return c >= `KEY_SET_FIRST && c <= `KEY_SET_LAST &&
           (filt || c < `KEY_FILT_FIRST || c > `KEY_FILT_LAST);
  endfunction

  logic                      press;
  logic [4:0]                pcode;
  panel_pkg::state_type      state_reg;
  panel_pkg::state_type      state_next;
  logic                      remote_reg;
  logic                      lock_reg;
  logic                      warn_reg;
  logic                      alert_reg;
  logic [4:0]                addr_reg;
  logic [SET_W-1:0]          setting_reg [NUM_SET];
  logic [SET_W-1:0]          setup_mem_reg [NUM_SLOT][NUM_SET];
  logic [3:0]                sel_reg;
  logic [SET_W-1:0]          edit_reg;
  logic                      edit_seen_reg;
  logic [3:0]                slot_reg;
  logic                      slot_seen_reg;
  logic [31:0]               timer_reg;
  logic                      timeout;
  logic                      key_ok;
  logic                      k_enter;
  logic                      k_reset;
  logic                      k_digit;
  logic                      k_set;
  logic                      remote_ok;
  logic                      store_go;
  logic                      recall_go;
  logic                      addr_go;
  logic                      set_go;
  logic                      lock_go;
  logic                      alarm_clr;
  logic                      warn_hit;
  logic                      alert_hit;

  key_event u_keys
  (
    .clk        (CLK),
    .rst        (RST),
    .key_valid  (KEY_VALID),
    .key_code   (KEY_CODE),
    .press      (press),
    .press_code (pcode)
  );

  // key qualification
  assign key_ok    = press && !remote_reg &&
                     (!lock_reg || pcode == `KEY_ENTER ||
                      pcode == `KEY_RESET);
  assign k_enter   = key_ok && pcode == `KEY_ENTER;
  assign k_reset   = key_ok && pcode == `KEY_RESET;
  assign k_digit   = key_ok && is_digit(pcode);
  assign k_set     = key_ok && setting_key(pcode, FILTER_FITTED);
  assign remote_ok = REMOTE_CMD && SERIAL_FITTED && MODE_STRAP &&
                     addr_reg != `ADDR_RESET && !remote_reg;
  assign store_go  = state_reg == panel_pkg::ST_STORE && k_enter &&
                     slot_seen_reg && 32'(slot_reg) < NUM_SLOT;
  assign recall_go = state_reg == panel_pkg::ST_RECALL && k_enter &&
                     slot_seen_reg && 32'(slot_reg) < NUM_SLOT;
  assign addr_go   = state_reg == panel_pkg::ST_ADDR && k_enter &&
                     edit_seen_reg && edit_reg <= SET_W'(`ADDR_MAX);
  assign set_go    = state_reg == panel_pkg::ST_SHOW && k_enter &&
                     edit_seen_reg;
  assign lock_go   = state_reg == panel_pkg::ST_PREFIX && k_reset;
  assign alarm_clr = state_reg == panel_pkg::ST_NORMAL && k_reset;
  assign warn_hit  = DC_VALUE > setting_reg[`SET_WARN_IDX];
  assign alert_hit = DC_VALUE > setting_reg[`SET_ALERT_IDX];
  assign timeout   = state_reg != panel_pkg::ST_NORMAL &&
                     timer_reg == (state_reg == panel_pkg::ST_BANNER ?
                                   BANNER_LAST : SHOW_LAST);

  // command sequencing
  always_comb
  begin
    state_next = state_reg;
    if (remote_reg || remote_ok)
      state_next = panel_pkg::ST_NORMAL;
    else if (timeout && !press)
      state_next = panel_pkg::ST_NORMAL;
    else
    begin
      case (state_reg)
        panel_pkg::ST_NORMAL:
          if (k_enter)
            state_next = panel_pkg::ST_PREFIX;
          else if (k_set)
            state_next = panel_pkg::ST_SHOW;
        panel_pkg::ST_SHOW:
          if (k_enter)
            state_next = panel_pkg::ST_NORMAL;
        panel_pkg::ST_PREFIX:
          if (key_ok)
          begin
            if (pcode == `KEY_STORE_SEL)
              state_next = panel_pkg::ST_STORE;
            else if (pcode == `KEY_RECALL_SEL)
              state_next = panel_pkg::ST_RECALL;
            else if (pcode == `KEY_ADDR_SEL && SERIAL_FITTED)
              state_next = panel_pkg::ST_ADDR;
            else if (pcode == `KEY_RESET)
              state_next = panel_pkg::ST_BANNER;
            else
              state_next = panel_pkg::ST_NORMAL;
          end
        panel_pkg::ST_STORE,
        panel_pkg::ST_RECALL,
        panel_pkg::ST_ADDR:
          if (k_enter)
            state_next = panel_pkg::ST_NORMAL;
        panel_pkg::ST_BANNER:
          state_next = panel_pkg::ST_BANNER;
        default:
          state_next = panel_pkg::ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      state_reg <= panel_pkg::ST_NORMAL;
    else
      state_reg <= state_next;
  end

  // idle timer, restarted by any press or state change
  always_ff @(posedge CLK)
  begin
    if (RST || press || state_next != state_reg ||
        state_reg == panel_pkg::ST_NORMAL)
      timer_reg <= 32'h0000_0000;
    else
      timer_reg <= timer_reg + 32'h0000_0001;
  end

  // control mode
  always_ff @(posedge CLK)
  begin
    if (RST)
      remote_reg <= 1'b0;
    else if (remote_ok)
      remote_reg <= 1'b1;
    else if (LOCAL_CMD)
      remote_reg <= 1'b0;
  end

  // keyboard lock
  always_ff @(posedge CLK)
  begin
    if (RST)
      lock_reg <= 1'b0;
    else if (lock_go)
      lock_reg <= !lock_reg;
  end

  // serial address
  always_ff @(posedge CLK)
  begin
    if (RST)
      addr_reg <= `ADDR_RESET;
    else if (addr_go)
      addr_reg <= edit_reg[4:0];
  end

  // alarms: a level still exceeded wins over the reset key
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      warn_reg  <= 1'b0;
      alert_reg <= 1'b0;
    end
    else
    begin
      warn_reg  <= warn_hit || (warn_reg && !alarm_clr);
      alert_reg <= alert_hit || (alert_reg && !alarm_clr);
    end
  end

  // edited value and selected setting
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      sel_reg       <= 4'h0;
      edit_reg      <= '0;
      edit_seen_reg <= 1'b0;
    end
    else if (k_set && (state_reg == panel_pkg::ST_NORMAL ||
                       state_reg == panel_pkg::ST_SHOW))
    begin
      sel_reg       <= 4'(pcode - `KEY_SET_FIRST);
      edit_reg      <= setting_reg[4'(pcode - `KEY_SET_FIRST)];
      edit_seen_reg <= 1'b0;
    end
    else if (state_reg == panel_pkg::ST_PREFIX && key_ok &&
             pcode == `KEY_ADDR_SEL)
    begin
      edit_reg      <= SET_W'(addr_reg);
      edit_seen_reg <= 1'b0;
    end
    else if (k_digit && (state_reg == panel_pkg::ST_SHOW ||
                         state_reg == panel_pkg::ST_ADDR))
    begin
      edit_reg      <= SET_W'(32'(edit_seen_reg ? edit_reg : '0) * 32'd10
                              + 32'(pcode));
      edit_seen_reg <= 1'b1;
    end
  end

  // slot number for store and recall
  always_ff @(posedge CLK)
  begin
    if (RST || state_reg == panel_pkg::ST_PREFIX)
    begin
      slot_reg      <= 4'h0;
      slot_seen_reg <= 1'b0;
    end
    else if (k_digit && (state_reg == panel_pkg::ST_STORE ||
                         state_reg == panel_pkg::ST_RECALL))
    begin
      slot_reg      <= pcode[3:0];
      slot_seen_reg <= 1'b1;
    end
  end

  // active setup
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < NUM_SET; i++)
        setting_reg[i] <= SET_W'(`SETTING_RESET);
      setting_reg[`SET_WARN_IDX]  <= SET_W'(`ALARM_LEVEL_RESET);
      setting_reg[`SET_ALERT_IDX] <= SET_W'(`ALARM_LEVEL_RESET);
    end
    else if (set_go)
      setting_reg[sel_reg] <= edit_reg;
    else if (recall_go)
    begin
      for (int i = 0; i < NUM_SET; i++)
        setting_reg[i] <= setup_mem_reg[slot_reg][i];
    end
    else if (remote_reg && HOST_SET_VALID && 32'(HOST_SET_SEL) < NUM_SET)
      setting_reg[HOST_SET_SEL] <= HOST_SET_DATA;
  end

  // stored setups
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int s = 0; s < NUM_SLOT; s++)
        for (int i = 0; i < NUM_SET; i++)
          setup_mem_reg[s][i] <= SET_W'(`SETTING_RESET);
    end
    else if (store_go)
    begin
      for (int i = 0; i < NUM_SET; i++)
        setup_mem_reg[slot_reg][i] <= setting_reg[i];
    end
  end

  // display
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      DISP_KIND  <= panel_pkg::DISP_READOUT;
      DISP_VALUE <= '0;
      DISP_FLASH <= 1'b0;
    end
    else if (remote_reg)
    begin
      DISP_KIND  <= panel_pkg::DISP_ADDR;
      DISP_VALUE <= SET_W'(addr_reg);
      DISP_FLASH <= 1'b0;
    end
    else
    begin
      DISP_KIND  <= panel_pkg::DISP_READOUT;
      DISP_VALUE <= DC_VALUE;
      DISP_FLASH <= 1'b0;
      case (state_reg)
        panel_pkg::ST_NORMAL:
          if (AC_OVERLOAD || DC_OVERLOAD)
          begin
            DISP_KIND  <= panel_pkg::DISP_OVERLOAD;
            DISP_FLASH <= 1'b1;
          end
        panel_pkg::ST_SHOW:
        begin
          DISP_KIND  <= panel_pkg::DISP_SETTING;
          DISP_VALUE <= edit_reg;
        end
        panel_pkg::ST_STORE:
        begin
          DISP_KIND  <= panel_pkg::DISP_STORE;
          DISP_VALUE <= SET_W'(slot_reg);
          DISP_FLASH <= 1'b1;
        end
        panel_pkg::ST_RECALL:
        begin
          DISP_KIND  <= panel_pkg::DISP_RECALL;
          DISP_VALUE <= SET_W'(slot_reg);
          DISP_FLASH <= 1'b1;
        end
        panel_pkg::ST_ADDR:
        begin
          DISP_KIND  <= panel_pkg::DISP_ADDR;
          DISP_VALUE <= edit_reg;
        end
        panel_pkg::ST_BANNER:
          DISP_KIND  <= lock_reg ? panel_pkg::DISP_LOCKED
                                 : panel_pkg::DISP_UNLOCKED;
        default:
          DISP_KIND  <= panel_pkg::DISP_READOUT;
      endcase
    end
  end

  assign WARN_LED    = warn_reg;
  assign ALERT_LED   = alert_reg;
  assign REMOTE_MODE = remote_reg;
  assign KBD_LOCKED  = lock_reg;
  assign SERIAL_ADDR = addr_reg;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence prefix_key(logic [4:0] k);
    state_reg == panel_pkg::ST_PREFIX && key_ok && pcode == k;
  endsequence

  sequence store_entered;
    state_reg == panel_pkg::ST_STORE ##1 DISP_FLASH &&
    DISP_KIND == panel_pkg::DISP_STORE;
  endsequence

  power_on_local_a: assert property (disable iff (1'b0)
    RST |=> !REMOTE_MODE)
    else $error("not in panel mode after reset");

  remote_entry_a: assert property ($rose(REMOTE_MODE) |->
    $past(REMOTE_CMD && SERIAL_FITTED && MODE_STRAP) &&
    SERIAL_ADDR != 5'h00)
    else $error("serial mode entered without its conditions");

  overload_flash_a: assert property (!remote_reg &&
    state_reg == panel_pkg::ST_NORMAL && (AC_OVERLOAD || DC_OVERLOAD) |=>
    DISP_FLASH && DISP_KIND == panel_pkg::DISP_OVERLOAD)
    else $error("overload not flashed");

  alarm_led_a: assert property (warn_hit && alert_hit |=>
    WARN_LED && ALERT_LED)
    else $error("alarm LED dark while level exceeded");

  alarm_clear_a: assert property (alarm_clr && !warn_hit && !alert_hit |=>
    !WARN_LED && !ALERT_LED)
    else $error("reset key did not clear both alarms");

  show_timeout_a: assert property (state_reg == panel_pkg::ST_SHOW &&
    timer_reg == SHOW_LAST && !press |=>
    state_reg == panel_pkg::ST_NORMAL)
    else $error("shown setting did not time out");

  store_entry_a: assert property (prefix_key(`KEY_STORE_SEL) |=>
    store_entered)
    else $error("store mode not entered with flashing prompt");

  store_write_a: assert property (store_go |=>
    setup_mem_reg[$past(slot_reg)][0] == $past(setting_reg[0]) &&
    state_reg == panel_pkg::ST_NORMAL)
    else $error("setup not stored");

  recall_load_a: assert property (recall_go |=>
    setting_reg[`SET_WARN_IDX] ==
    $past(setup_mem_reg[slot_reg][`SET_WARN_IDX]))
    else $error("setup not recalled");

  prompt_timeout_a: assert property (state_reg == panel_pkg::ST_RECALL &&
    timer_reg == SHOW_LAST && !press |=>
    state_reg == panel_pkg::ST_NORMAL ##1
    DISP_KIND != panel_pkg::DISP_RECALL)
    else $error("recall mode did not time out");

  lock_toggle_a: assert property (prefix_key(`KEY_RESET) |=>
    KBD_LOCKED != $past(KBD_LOCKED) ##1
    (DISP_KIND == (KBD_LOCKED ? panel_pkg::DISP_LOCKED
                              : panel_pkg::DISP_UNLOCKED)))
    else $error("lock toggle or banner wrong");

  locked_ignore_a: assert property (lock_reg && press && !remote_reg &&
    state_reg == panel_pkg::ST_NORMAL && pcode != `KEY_ENTER &&
    pcode != `KEY_RESET |=> state_reg == panel_pkg::ST_NORMAL)
    else $error("locked keyboard acted on a key");

  remote_display_a: assert property (REMOTE_MODE |=>
    DISP_KIND == panel_pkg::DISP_ADDR &&
    DISP_VALUE == SET_W'($past(SERIAL_ADDR)))
    else $error("serial mode not showing address");

  addr_install_a: assert property (addr_go |=>
    SERIAL_ADDR == $past(edit_reg[4:0]) && SERIAL_ADDR <= 5'h10)
    else $error("address not installed");

endmodule

`default_nettype wire

/* tb/panel_partner.sv */
`default_nettype none

module panel_partner
(
  // clock
  input  wire logic       clk,
  // keypad
  output logic            key_valid,
  output logic [4:0]      key_code,
  // serial host
  output logic            remote_cmd,
  output logic            local_cmd,
  output logic            set_valid,
  output logic [3:0]      set_sel,
  output logic [9:0]      set_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    key_valid = 1'b0;
    key_code = 5'h1f;
    remote_cmd = 1'b0;
    local_cmd = 1'b0;
    set_valid = 1'b0;
    set_sel = 4'hf;
    set_data = 10'h3ff;
  end

  // one press, released between presses, code scrambled when released
  task automatic press(input logic [4:0] c);
    @(posedge clk);
    #1 key_valid = 1'b1;
    key_code = c;
    @(posedge clk);
    #1 key_valid = 1'b0;
    key_code = ~c;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // single unit on the host, so it is the only addressed talker
  task automatic host(input bit go_remote);
    @(posedge clk);
    #1 remote_cmd = go_remote;
    local_cmd = !go_remote;
    @(posedge clk);
    #1 remote_cmd = 1'b0;
    local_cmd = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic host_set(input logic [3:0] s, input logic [9:0] d);
    @(posedge clk);
    #1 set_valid = 1'b1;
    set_sel = s;
    set_data = d;
    @(posedge clk);
    #1 set_valid = 1'b0;
    set_sel = ~s;
    set_data = ~d;
    repeat (3) @(posedge clk);
    #1;
  endtask
endmodule

`default_nettype wire

/* tb/tb.sv */
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rst;
  logic        filt_fit;
  logic        ser_fit;
  logic        strap;
  logic        ac_ovl;
  logic        dc_ovl;
  logic [9:0]  dc_val;
  wire logic   kv;
  wire logic [4:0] kc;
  wire logic   rc;
  wire logic   lc;
  wire logic   hv;
  wire logic [3:0] hs;
  wire logic [9:0] hd;
  panel_pkg::disp_kind_type kind;
  logic [9:0]  dval;
  logic        flash;
  logic        warn;
  logic        alert;
  logic        rmode;
  logic        locked;
  logic [4:0]  addr;
  int          error_cnt;
  int          n_compared;
  logic [31:0] seed;
  int          set_m[10];
  int          slot_m[10];
  int          addr_m;
  int          v;
  int          s;

  panel_keypad_command_fsm #(.SHOW_CYCLES(40), .BANNER_CYCLES(20)) dut
  (
    .CLK(clk), .RST(rst), .KEY_VALID(kv), .KEY_CODE(kc),
    .FILTER_FITTED(filt_fit), .SERIAL_FITTED(ser_fit),
    .MODE_STRAP(strap), .REMOTE_CMD(rc), .LOCAL_CMD(lc),
    .HOST_SET_VALID(hv), .HOST_SET_SEL(hs), .HOST_SET_DATA(hd),
    .AC_OVERLOAD(ac_ovl), .DC_OVERLOAD(dc_ovl), .DC_VALUE(dc_val),
    .DISP_KIND(kind), .DISP_VALUE(dval), .DISP_FLASH(flash),
    .WARN_LED(warn), .ALERT_LED(alert), .REMOTE_MODE(rmode),
    .KBD_LOCKED(locked), .SERIAL_ADDR(addr)
  );

  panel_partner op
  (
    .clk(clk), .key_valid(kv), .key_code(kc), .remote_cmd(rc),
    .local_cmd(lc), .set_valid(hv), .set_sel(hs), .set_data(hd)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic seq(input int q[$]);
    foreach (q[i]) op.press(5'(q[i]));
    w(1);
  endtask

  task automatic digits(input int x);
    if (x >= 100) op.press(5'(x / 100));
    if (x >= 10) op.press(5'((x / 10) % 10));
    op.press(5'(x % 10));
  endtask

  // key in a setting and accept it, model follows
  task automatic set_key(input int idx, input int x);
    op.press(5'(12 + idx));
    digits(x);
    seq('{10});
    set_m[idx] = x;
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    w(8000);
    error_cnt++;
    close_out();
  end

  initial
  begin
    seed = 32'h0001_5e80;
    foreach (set_m[i]) set_m[i] = (i >= 8) ? 1023 : 0;
    foreach (slot_m[i]) slot_m[i] = 0;
    addr_m = 0;
    {filt_fit, ac_ovl, dc_ovl, strap} = 4'h0;
    ser_fit = 1'b1;
    dc_val = 10'h000;
    rst = 1'b1;
    w(12);
    rst = 1'b0;
    w(2);
    chk(kind, panel_pkg::DISP_READOUT);
    chk(rmode, 0);
    chk(addr, 0);
    v = rnd() % 90 + 5;
    set_key(8, v);
    set_key(9, v + 10);
    dc_val = 10'(v);
    w(3);
    chk(warn, 0);
    dc_val = 10'(v + 11);
    w(3);
    chk({warn, alert}, 2'b11);
    dc_val = 10'(v);
    op.press(11);
    w(1);
    chk({warn, alert}, 2'b00);
    seq('{12});
    chk(kind, panel_pkg::DISP_SETTING);
    chk(dval, 16'(set_m[0]));
    w(45);
    chk(kind, panel_pkg::DISP_READOUT);
    seq('{18});
    chk(kind, panel_pkg::DISP_READOUT);
    filt_fit = 1'b1;
    seq('{18});
    chk(kind, panel_pkg::DISP_SETTING);
    seq('{10});
    filt_fit = 1'b0;
    ac_ovl = 1'b1;
    w(3);
    chk({kind, flash}, {panel_pkg::DISP_OVERLOAD, 1'b1});
    {ac_ovl, dc_ovl} = 2'b01;
    w(3);
    chk({kind, flash}, {panel_pkg::DISP_OVERLOAD, 1'b1});
    dc_ovl = 1'b0;
    w(3);
    chk({kind, flash}, {panel_pkg::DISP_READOUT, 1'b0});
    v = rnd() % 100;
    set_key(0, v);
    seq('{10, 1});
    chk({kind, flash}, {panel_pkg::DISP_STORE, 1'b1});
    s = rnd() % 10;
    seq('{s, 10});
    slot_m[s] = set_m[0];
    chk(kind, panel_pkg::DISP_READOUT);
    set_key(0, (v + 1) % 100);
    seq('{10, 6});
    chk({kind, flash}, {panel_pkg::DISP_RECALL, 1'b1});
    seq('{s, 10, 12});
    set_m[0] = slot_m[s];
    chk(dval, 16'(set_m[0]));
    seq('{10, 10, 1});
    w(45);
    chk(kind, panel_pkg::DISP_READOUT);
    seq('{10, 11});
    chk({locked, kind}, {1'b1, panel_pkg::DISP_LOCKED});
    w(25);
    seq('{12});
    chk(kind, panel_pkg::DISP_READOUT);
    seq('{10, 11});
    chk({locked, kind}, {1'b0, panel_pkg::DISP_UNLOCKED});
    w(25);
    ser_fit = 1'b0;
    seq('{10, 3});
    chk(kind, panel_pkg::DISP_READOUT);
    ser_fit = 1'b1;
    seq('{10, 3});
    chk({kind, dval}, {panel_pkg::DISP_ADDR, 10'(addr_m)});
    addr_m = rnd() % 16 + 1;
    digits(addr_m);
    seq('{10});
    chk(addr, 16'(addr_m));
    seq('{10, 3, 1, 7, 10});
    chk(addr, 16'(addr_m));
    op.host(1'b1);
    chk(rmode, 0);
    strap = 1'b1;
    ser_fit = 1'b0;
    op.host(1'b1);
    chk(rmode, 0);
    ser_fit = 1'b1;
    op.host(1'b1);
    chk(rmode, 1);
    seq('{12});
    chk({kind, dval}, {panel_pkg::DISP_ADDR, 10'(addr_m)});
    op.host_set(4'h8, 10'h000);
    dc_val = 10'h001;
    w(3);
    chk(warn, 1);
    op.host(1'b0);
    seq('{10, 3, 0, 10});
    op.host(1'b1);
    chk({rmode, addr}, 6'h00);
    close_out();
  end
endmodule

`default_nettype wire
